// ==== verilog/acs_in_scale.sv ====
/*
 input path: classifies a raw nickel climate reading and applies
 the wire-break substitute rules. assumes readings synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module acs_in_scale import acs_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sample_valid, // one-cycle strobe with a new reading
	input wire logic signed [15:0] sample_raw, // reading in 0.01 degree steps
	input wire logic wire_open, // sensor line found open
	input wire logic diag_break_en, // wire-break diagnostics enabled
	input wire logic diag_limit_en, // overflow/underflow diagnostics enabled
	output logic signed [15:0] in_code_r, // reported input code
	output acs_class_e in_class_r, // range class of the last reading
	output logic in_valid_r, // pulse: new code present
	output logic break_alarm_r, // pulse: wire-break alarm
	output logic low_alarm_r, // pulse: low limit violated
	output logic high_alarm_r // pulse: high limit violated
);
	logic signed [15:0] code_nxt;
	acs_class_e class_nxt;
	logic brk_nxt;
	logic low_nxt;
	logic high_nxt;

	// classify and substitute; wire break is checked first
	always_comb begin
		code_nxt = sample_raw;
		class_nxt = ACS_NOMINAL;
		brk_nxt = 1'b0;
		low_nxt = 1'b0;
		high_nxt = 1'b0;
		if (wire_open && diag_break_en) begin
			code_nxt = ACS_OVERFLOW;
			class_nxt = ACS_OVERFLOW_C;
			brk_nxt = 1'b1;
		end else if (wire_open) begin
			code_nxt = ACS_UNDERFLOW;
			class_nxt = ACS_UNDERFLOW_C;
			low_nxt = diag_limit_en; // alarm only when enabled
		end else if (sample_raw > ACS_OVR_HI) begin
			code_nxt = ACS_OVERFLOW;
			class_nxt = ACS_OVERFLOW_C;
			high_nxt = diag_limit_en;
		end else if (sample_raw < ACS_UND_LO) begin
			code_nxt = ACS_UNDERFLOW;
			class_nxt = ACS_UNDERFLOW_C;
			low_nxt = diag_limit_en;
		end else if (sample_raw > ACS_NOM_HI) begin
			class_nxt = ACS_OVERRANGE;
		end else if (sample_raw < ACS_NOM_LO) begin
			class_nxt = ACS_UNDERRANGE;
		end
	end

	// code and class register, updated per reading
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			in_code_r <= ACS_RESET_CODE;
			in_class_r <= ACS_NOMINAL;
		end else if (sample_valid) begin
			in_code_r <= code_nxt;
			in_class_r <= class_nxt;
		end
	end

	// one-cycle event pulses
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			in_valid_r <= 1'b0;
			break_alarm_r <= 1'b0;
			low_alarm_r <= 1'b0;
			high_alarm_r <= 1'b0;
		end else begin
			in_valid_r <= sample_valid;
			break_alarm_r <= sample_valid && brk_nxt;
			low_alarm_r <= sample_valid && low_nxt;
			high_alarm_r <= sample_valid && high_nxt;
		end
	end

	// with break diagnostics on, a broken line reports only the break code and alarm, never a limit alarm
	wo_prio_a: assert property (@(posedge clk) disable iff (!reset_n)
		sample_valid && wire_open && diag_break_en |=> in_code_r == ACS_OVERFLOW
		&& break_alarm_r && !low_alarm_r && !high_alarm_r)
		else $error("wire break not prioritised");
	open_sub_a: assert property (@(posedge clk) disable iff (!reset_n)
		sample_valid && wire_open && !diag_break_en |=> in_code_r == ACS_UNDERFLOW
		&& (low_alarm_r == $past(diag_limit_en)) && !break_alarm_r)
		else $error("open line substitute wrong");
	over_code_a: assert property (@(posedge clk) disable iff (!reset_n)
		sample_valid && !wire_open && sample_raw > ACS_OVR_HI |=> in_code_r == ACS_OVERFLOW)
		else $error("overflow code wrong");
	under_code_a: assert property (@(posedge clk) disable iff (!reset_n)
		sample_valid && !wire_open && sample_raw < ACS_UND_LO |=> in_code_r == ACS_UNDERFLOW)
		else $error("underflow code wrong");
	no_alarm_a: assert property (@(posedge clk) disable iff (!reset_n)
		sample_valid && !diag_break_en && !diag_limit_en |=> !break_alarm_r && !low_alarm_r
		&& !high_alarm_r) else $error("alarm while disabled");
	// without a strobe the reported code stays put and no pulse appears
	in_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		!sample_valid |=> $stable(in_code_r) && !in_valid_r)
		else $error("input code moved without sample");
endmodule
`default_nettype wire

// ==== verilog/acs_pkg.sv ====
/*
 analog code scaling package: code limits, substitute codes, range class enum.
 assumes a 10 MHz single clock domain; no software-visible registers.
*/
// Behaviour
// - nickel climate input: 0.01 degree codes, 7FFF/8000 substituted beyond 155.00/-105.00
// - enabled diagnostic events raise record and interrupt
// - wire break enabled forces 7FFF plus alarm
// - wire break outranks overflow and underflow
// - break disabled, limits enabled: 8000, low alarm
// - both disabled: 8000 substitute, no alarm
// - output words are 16-bit two's complement
// - 27648 is full scale, zero is zero
// - bipolar overrange and underrange classified, still driven
// - codes above 32511 saturate at 32511
// - bipolar codes below -32512 saturate at -32512
// - unipolar negative codes give zero output
package acs_pkg;
	localparam int ACS_W = 16; // code word width
	localparam logic signed [15:0] ACS_NOM_HI = 16'sh32C8; // 130.00 degrees
	localparam logic signed [15:0] ACS_NOM_LO = -16'sh1770; // -60.00 degrees
	localparam logic signed [15:0] ACS_OVR_HI = 16'sh3C8C; // 155.00 ceiling
	localparam logic signed [15:0] ACS_UND_LO = -16'sh2904; // -105.00 floor
	localparam logic signed [15:0] ACS_OVERFLOW = 16'sh7FFF; // overflow / wire break code
	localparam logic signed [15:0] ACS_UNDERFLOW = 16'sh8000; // underflow / open line code
	localparam logic signed [15:0] ACS_FULL = 16'sh6C00; // +100 percent
	localparam logic signed [15:0] ACS_OUT_MAX = 16'sh7EFF; // +117.589 percent
	localparam logic signed [15:0] ACS_OUT_MIN = -16'sh7F00; // -117.593 percent
	localparam logic signed [15:0] ACS_ZERO = 16'sh0000; // zero output
	localparam logic signed [15:0] ACS_RESET_CODE = 16'sh0000; // code after reset
	// measurement range class of a code
	typedef enum logic [2:0] {
		ACS_NOMINAL,
		ACS_OVERRANGE,
		ACS_UNDERRANGE,
		ACS_OVERFLOW_C,
		ACS_UNDERFLOW_C
	} acs_class_e;
endpackage

// ==== verilog/acs_out_clamp.sv ====
/*
 output path: clamps one 16-bit output word per bipolar/unipolar range
 and holds it. assumes writes synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module acs_out_clamp import acs_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic wr_en, // one-cycle write strobe
	input wire logic signed [15:0] wr_code, // two's complement word
	input wire logic unipolar, // 1 selects a unipolar range
	output logic signed [15:0] dac_code_r, // clamped code to converter
	output logic over_r, // held: last code in overrange
	output logic under_r // held: last code in underrange
);
	logic signed [15:0] clamp_nxt;

	// saturate; negative floor depends on polarity
	always_comb begin
		clamp_nxt = wr_code;
		if (wr_code > ACS_OUT_MAX) begin
			clamp_nxt = ACS_OUT_MAX;
		end else if (unipolar && wr_code < ACS_ZERO) begin
			clamp_nxt = ACS_ZERO;
		end else if (!unipolar && wr_code < ACS_OUT_MIN) begin
			clamp_nxt = ACS_OUT_MIN;
		end
	end

	// hold last clamped word until the next write
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dac_code_r <= ACS_RESET_CODE;
			over_r <= 1'b0;
			under_r <= 1'b0;
		end else if (wr_en) begin
			dac_code_r <= clamp_nxt;
			over_r <= clamp_nxt > ACS_FULL;
			under_r <= !unipolar && clamp_nxt < -ACS_FULL;
		end
	end

	sat_hi_a: assert property (@(posedge clk) disable iff (!reset_n)
		wr_en && wr_code > ACS_OUT_MAX |=> dac_code_r == ACS_OUT_MAX)
		else $error("high saturation wrong");
	sat_lo_a: assert property (@(posedge clk) disable iff (!reset_n)
		wr_en && !unipolar && wr_code < ACS_OUT_MIN |=> dac_code_r == ACS_OUT_MIN)
		else $error("low saturation wrong");
	uni_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
		wr_en && unipolar && wr_code < ACS_ZERO |=> dac_code_r == ACS_ZERO)
		else $error("unipolar floor wrong");
	pass_thru_a: assert property (@(posedge clk) disable iff (!reset_n)
		wr_en && wr_code <= ACS_FULL && wr_code >= -ACS_FULL && !(unipolar && wr_code < 0)
		|=> dac_code_r == $past(wr_code)) else $error("nominal code altered");
	hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		!wr_en |=> $stable(dac_code_r)) else $error("code changed without write");
	bip_class_a: assert property (@(posedge clk) disable iff (!reset_n)
		wr_en && !unipolar && wr_code > ACS_FULL |=> over_r && !under_r)
		else $error("overrange class wrong");
	// the negative side of the bipolar class, saturated codes included
	bip_under_a: assert property (@(posedge clk) disable iff (!reset_n)
		wr_en && !unipolar && wr_code < -ACS_FULL |=> under_r && !over_r)
		else $error("underrange class wrong");
endmodule
`default_nettype wire

// ==== verilog/acs_top.sv ====
/*
 analog code scaling top: one input channel and one output channel,
 plus diagnostics record and interrupt. assumes one 10 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module acs_top import acs_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sample_valid, // new reading strobe
	input wire logic signed [15:0] sample_raw, // reading, 0.01 degree per step
	input wire logic wire_open, // open line detected
	input wire logic diag_break_en, // wire-break diagnostics parameter
	input wire logic diag_limit_en, // overflow/underflow diagnostics parameter
	input wire logic diag_ack, // controller took the diagnostics record
	input wire logic out_wr, // output write strobe
	input wire logic signed [15:0] out_code, // output word
	input wire logic out_unipolar, // output range is unipolar
	output logic signed [15:0] in_code, // reported input code
	output acs_class_e in_class, // input range class
	output logic in_valid, // pulse with new input code
	output logic signed [15:0] dac_code, // clamped output to converter
	output logic out_over, // output in overrange
	output logic out_under, // output in underrange
	output logic [2:0] diag_record_r, // sticky record: {high, low, break}
	output logic diag_irq_r // diagnostics interrupt level
);
	logic brk;
	logic low;
	logic high;
	logic [2:0] evt;

	acs_in_scale u_in (
		.clk(clk), .reset_n(reset_n), .sample_valid(sample_valid),
		.sample_raw(sample_raw), .wire_open(wire_open),
		.diag_break_en(diag_break_en), .diag_limit_en(diag_limit_en),
		.in_code_r(in_code), .in_class_r(in_class), .in_valid_r(in_valid),
		.break_alarm_r(brk), .low_alarm_r(low), .high_alarm_r(high)
	);

	acs_out_clamp u_out (
		.clk(clk), .reset_n(reset_n), .wr_en(out_wr), .wr_code(out_code),
		.unipolar(out_unipolar), .dac_code_r(dac_code),
		.over_r(out_over), .under_r(out_under)
	);

	assign evt = {high, low, brk};

	// diagnostics record: a new event wins over an acknowledge in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			diag_record_r <= 3'h0;
		end else begin
			diag_record_r <= (diag_ack ? 3'h0 : diag_record_r) | evt;
		end
	end

	// interrupt stands while any record bit is pending
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			diag_irq_r <= 1'b0;
		end else begin
			diag_irq_r <= ((diag_ack ? 3'h0 : diag_record_r) | evt) != 3'h0;
		end
	end

	irq_raise_a: assert property (@(posedge clk) disable iff (!reset_n)
		evt != 3'h0 |=> diag_irq_r && (diag_record_r & $past(evt)) == $past(evt))
		else $error("event did not raise interrupt");
	// an acknowledge with no new event empties the record and drops the interrupt
	ack_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
		diag_ack && evt == 3'h0 |=> diag_record_r == 3'h0 && !diag_irq_r)
		else $error("record not cleared by acknowledge");
	// the record is sticky: nothing but an event or an acknowledge moves it
	rec_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		!diag_ack && evt == 3'h0 |=> $stable(diag_record_r))
		else $error("record moved without cause");
endmodule
`default_nettype wire

// ==== testbench/acs_ctrl_model.sv ====
/*
 control program model: acknowledges the diagnostics record.
 assumes the irq level is settled by the falling clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module acs_ctrl_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic irq, // diagnostics interrupt level
	input wire logic slow, // 1: answer one cycle later, like a busy scan
	output logic diag_ack // acknowledge pulse to the record
);
	logic seen_r; // irq was already up last cycle
	// acknowledge off the falling edge so the design samples a settled level
	always @(negedge clk or negedge reset_n) begin
		if (!reset_n) begin
			seen_r <= 1'b0;
			diag_ack <= 1'b0;
		end else begin
			seen_r <= irq;
			diag_ack <= irq & (!slow | seen_r);
		end
	end
endmodule
`default_nettype wire

// ==== testbench/analog_code_scaling_tb_top.sv ====
/*
 acs_top bench: a case table for both paths, then reset and back-to-back.
 assumes acs_pkg and the control program model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module analog_code_scaling_tb_top;
	import acs_pkg::*;
	// out flag, code, {open, brk_en, lim_en, unipolar}, code, flags, class
	typedef struct packed {
		logic o;
		logic [15:0] c;
		logic [3:0] f;
		logic [15:0] ec;
		logic [2:0] ef;
		logic [2:0] cl;
	} acs_row_s;
	localparam acs_row_s ROWS[31] = '{
		{1'b1,16'h6C00,4'h0,16'h6C00,3'h0,3'h0}, {1'b1,16'h6C01,4'h0,16'h6C01,3'h2,3'h0},
		{1'b1,16'h7EFF,4'h0,16'h7EFF,3'h2,3'h0}, {1'b1,16'h7F00,4'h0,16'h7EFF,3'h2,3'h0},
		{1'b1,16'h7FFF,4'h0,16'h7EFF,3'h2,3'h0}, {1'b1,16'h9400,4'h0,16'h9400,3'h0,3'h0},
		{1'b1,16'h93FF,4'h0,16'h93FF,3'h1,3'h0}, {1'b1,16'h8100,4'h0,16'h8100,3'h1,3'h0},
		{1'b1,16'h80FF,4'h0,16'h8100,3'h1,3'h0}, {1'b1,16'h8000,4'h0,16'h8100,3'h1,3'h0},
		{1'b1,16'h0000,4'h0,16'h0000,3'h0,3'h0}, {1'b1,16'hFFFF,4'h0,16'hFFFF,3'h0,3'h0},
		{1'b1,16'hFFFF,4'h1,16'h0000,3'h0,3'h0}, {1'b1,16'h8000,4'h1,16'h0000,3'h0,3'h0},
		{1'b1,16'h6C01,4'h1,16'h6C01,3'h2,3'h0}, {1'b1,16'h7F00,4'h1,16'h7EFF,3'h2,3'h0},
		{1'b0,16'h32C8,4'h0,16'h32C8,3'h0,3'h0}, {1'b0,16'h32C9,4'h0,16'h32C9,3'h0,3'h1},
		{1'b0,16'h3C8C,4'h0,16'h3C8C,3'h0,3'h1}, {1'b0,16'h3C8D,4'h2,16'h7FFF,3'h4,3'h3},
		{1'b0,16'h3C8D,4'h0,16'h7FFF,3'h0,3'h3}, {1'b0,16'hE890,4'h0,16'hE890,3'h0,3'h0},
		{1'b0,16'hE88F,4'h0,16'hE88F,3'h0,3'h2}, {1'b0,16'hD6FC,4'h0,16'hD6FC,3'h0,3'h2},
		{1'b0,16'hD6FB,4'h2,16'h8000,3'h2,3'h4}, {1'b0,16'hD6FB,4'hE,16'h7FFF,3'h1,3'h0},
		{1'b0,16'h3C8D,4'hE,16'h7FFF,3'h1,3'h0}, {1'b0,16'h0000,4'hC,16'h7FFF,3'h1,3'h0},
		{1'b0,16'h0000,4'hA,16'h8000,3'h2,3'h0}, {1'b0,16'h0000,4'h8,16'h8000,3'h0,3'h0},
		{1'b0,16'h3C8D,4'h6,16'h7FFF,3'h4,3'h3}};
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic sample_valid = 1'b0;
	logic signed [15:0] sample_raw = 16'sh0000;
	logic wire_open = 1'b0;
	logic diag_break_en = 1'b0;
	logic diag_limit_en = 1'b0;
	logic diag_ack; // from the control program model
	logic out_wr = 1'b0;
	logic signed [15:0] out_code = 16'sh0000;
	logic out_unipolar = 1'b0;
	logic slow = 1'b0; // model answer speed
	logic signed [15:0] in_code, dac_code;
	acs_class_e in_class;
	logic in_valid, out_over, out_under, diag_irq_r;
	logic [2:0] diag_record_r;
	int errors = 0;
	int checks_done = 0;
	int cycles = 0; // hang guard
	acs_row_s r;
	acs_top u_dut (.clk(clk), .reset_n(reset_n), .sample_valid(sample_valid),
		.sample_raw(sample_raw), .wire_open(wire_open), .diag_break_en(diag_break_en),
		.diag_limit_en(diag_limit_en), .diag_ack(diag_ack), .out_wr(out_wr),
		.out_code(out_code), .out_unipolar(out_unipolar), .in_code(in_code),
		.in_class(in_class), .in_valid(in_valid), .dac_code(dac_code), .out_over(out_over),
		.out_under(out_under), .diag_record_r(diag_record_r), .diag_irq_r(diag_irq_r));
	acs_ctrl_model u_ctrl (.clk(clk), .reset_n(reset_n), .irq(diag_irq_r), .slow(slow),
		.diag_ack(diag_ack));
	// 100 ns clock
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		$display("checks_done=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// the whole run is a few hundred cycles, so 2000 means a hang
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			summarize();
		end
	end
	initial begin
		repeat (4) @(negedge clk);
		chk(in_code, 16'h0000);
		chk(dac_code, 16'h0000);
		chk({12'h0, diag_irq_r, diag_record_r}, 16'h0000);
		reset_n = 1'b1;
		// table: one strobe per row, answer one cycle on, record a cycle later
		for (int i = 0; i < 31; i++) begin
			r = ROWS[i];
			@(negedge clk);
			{wire_open, diag_break_en, diag_limit_en, out_unipolar} = r.f;
			sample_raw = r.c;
			out_code = r.c;
			out_wr = r.o;
			sample_valid = !r.o;
			slow = i[0];
			@(negedge clk);
			out_wr = 1'b0;
			sample_valid = 1'b0;
			if (r.o) begin
				chk(dac_code, r.ec);
				chk({14'h0, out_over, out_under}, {14'h0, r.ef[1:0]});
			end else begin
				chk(in_code, r.ec);
				chk({15'h0, in_valid}, 16'h0001);
				if (!r.f[3]) chk({13'h0, in_class}, {13'h0, r.cl});
				@(negedge clk);
				chk({12'h0, diag_irq_r, diag_record_r}, {12'h0, |r.ef, r.ef});
			end
			repeat (4) @(negedge clk);
		end
		// only samples since the last write: the output must not move
		chk(dac_code, 16'h7EFF);
		// reset in mid-run with a record pending
		sample_raw = 16'sh3C8D;
		{wire_open, diag_break_en, diag_limit_en} = 3'h1;
		sample_valid = 1'b1;
		@(negedge clk);
		sample_valid = 1'b0;
		@(negedge clk);
		// the record must really be pending, or the reset check below proves nothing
		chk({12'h0, diag_irq_r, diag_record_r}, 16'h000C);
		reset_n = 1'b0;
		#10;
		chk({12'h0, diag_irq_r, diag_record_r}, 16'h0000);
		chk(in_code, 16'h0000);
		chk(dac_code, 16'h0000);
		@(negedge clk);
		reset_n = 1'b1;
		// back-to-back writes from the first edge after release
		out_unipolar = 1'b0;
		out_code = 16'sh7F00;
		out_wr = 1'b1;
		@(negedge clk);
		chk(dac_code, 16'h7EFF);
		chk({15'h0, in_valid}, 16'h0000);
		chk(in_code, 16'h0000);
		out_code = 16'sh80FF;
		@(negedge clk);
		out_wr = 1'b0;
		chk(dac_code, 16'h8100);
		summarize();
	end
endmodule
`default_nettype wire
